// ### src/alert_pkg.sv
package alert_pkg;

   // ------------------------------------------------------------
   // clock and square-wave timing
   // ------------------------------------------------------------
   localparam int CLK_HZ    = 25_000_000;
   localparam int SLOW_HZ   = 100;
   localparam int MID_HZ    = 1_000;
   localparam int FAST_HZ   = 10_000;
   // half periods in cycles, rounded down
   localparam int SLOW_HALF = CLK_HZ / (2 * SLOW_HZ);
   localparam int MID_HALF  = CLK_HZ / (2 * MID_HZ);
   localparam int FAST_HALF = CLK_HZ / (2 * FAST_HZ);

   // ------------------------------------------------------------
   // channels and results
   // ------------------------------------------------------------
   localparam int CHANNELS  = 6;
   localparam int RESULT_W  = 12;
   localparam int LIMIT_W   = 8;
   localparam int LIMIT_LSB = RESULT_W - LIMIT_W;
   typedef logic [RESULT_W-1:0]               result_t;
   typedef logic [CHANNELS-1:0][RESULT_W-1:0] bank_t;
   typedef logic [LIMIT_W-1:0]                limit_t;

   localparam int CELL_INPUT_FIVE = 4;
   localparam int CELL_INPUT_FOUR = 3;
   localparam int AUX_INPUT_FIVE  = 4;
   localparam int AUX_INPUT_THREE = 2;
   localparam int AUX_INPUT_ONE   = 0;
   // aux one, three and five
   localparam logic [CHANNELS-1:0] ODD_AUX = 6'h15;

   // ------------------------------------------------------------
   // device register indices
   // ------------------------------------------------------------
   localparam logic [4:0] IDX_CTRL_HI    = 5'h0d;
   localparam logic [4:0] IDX_CTRL_LO    = 5'h0e;
   localparam logic [4:0] IDX_CELL_OVER  = 5'h0f;
   localparam logic [4:0] IDX_CELL_UNDER = 5'h10;
   localparam logic [4:0] IDX_AUX_OVER   = 5'h11;
   localparam logic [4:0] IDX_AUX_UNDER  = 5'h12;
   localparam logic [4:0] IDX_ALERT_CFG  = 5'h13;

   localparam logic [7:0] CTRL_HI_RST    = 8'h00;
   localparam logic [7:0] CTRL_LO_RST    = 8'h03;
   localparam logic [7:0] ALERT_CFG_RST  = 8'h00;
   localparam logic [7:0] OVER_RST       = 8'hff;
   localparam logic [7:0] UNDER_RST      = 8'h00;

   // field positions
   localparam int SEL_LSB   = 6;
   localparam int MODE_LSB  = 6;
   localparam int FREQ_LSB  = 4;
   localparam int CMASK_LSB = 2;
   localparam int AMASK_LSB = 0;

   typedef enum logic [1:0] {
      MODE_OFF    = 2'b00,
      MODE_STATIC = 2'b01,
      MODE_SQUARE = 2'b10,
      MODE_PASS   = 2'b11
   } alert_mode_t;

   typedef enum logic [1:0] {
      FREQ_SLOW = 2'b00,
      FREQ_MID  = 2'b01,
      FREQ_FAST = 2'b10,
      FREQ_RSV  = 2'b11
   } freq_t;

   typedef enum logic [1:0] {
      MASK_NONE = 2'b00,
      MASK_ONE  = 2'b01,
      MASK_TWO  = 2'b10,
      MASK_RSV  = 2'b11
   } mask_t;

   typedef enum logic [1:0] {
      SEL_ALL     = 2'b00,
      SEL_ODD_AUX = 2'b01,
      SEL_CELLS   = 2'b10,
      SEL_SELF    = 2'b11
   } conv_sel_t;

   // ------------------------------------------------------------
   // host apb map
   // ------------------------------------------------------------
   localparam logic [11:0] HOST_CMD    = 12'h000;
   localparam logic [11:0] HOST_STATUS = 12'h004;
   localparam logic [11:0] HOST_RDATA  = 12'h008;
   localparam int CMD_DATA_LSB = 0;
   localparam int CMD_IDX_LSB  = 16;
   localparam int CMD_WE_BIT   = 24;
   localparam int ST_BUSY      = 0;
   localparam int ST_ALERT     = 1;
   localparam int ST_SEEN      = 2;
   localparam int ST_REFUSED   = 3;

endpackage

// ### src/alert_link_if.sv
`timescale 1ns/1ps
interface alert_link_if;
   logic       req;
   logic       we;
   logic [4:0] idx;
   logic [7:0] wdata;
   logic       ack;
   logic [7:0] rdata;
   logic       alert_level;

   modport dev  (input req, we, idx, wdata, output ack, rdata, alert_level);
   modport host (output req, we, idx, wdata, input ack, rdata, alert_level);
endinterface

// ### src/square_wave_gen.sv
`timescale 1ns/1ps
module square_wave_gen
   import alert_pkg::*;
#(
   parameter int SLOW = SLOW_HALF,
   parameter int MID  = MID_HALF,
   parameter int FAST = FAST_HALF
) (
   // clock and reset
   input  wire logic  clk,
   input  wire logic  rst_n,
   // control
   input  wire logic  run,
   input  wire freq_t freq,
   // wave
   output logic       wave
);
   import alert_pkg::*;

   localparam int CNT_W = $clog2(SLOW + 1);

   if (SLOW < 1 || MID < 1 || FAST < 1 || MID > SLOW || FAST > SLOW) begin : g_chk
      $error("bad half periods");
   end

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [CNT_W-1:0] half;
   logic             next_wave;

   always_comb begin
      unique case (freq)
         FREQ_SLOW: half = CNT_W'(SLOW - 1);
         FREQ_MID:  half = CNT_W'(MID - 1);
         default:   half = CNT_W'(FAST - 1);
      endcase
      next_cnt  = cnt;
      next_wave = wave;
      // idle high: restart gives a full high half
      if (!run) begin
         next_cnt  = '0;
         next_wave = 1'b1;
      end else if (cnt >= half) begin
         next_cnt  = '0;
         next_wave = ~wave;
      end else begin
         next_cnt = cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt  <= '0;
         wave <= 1'b1;
      end else begin
         cnt  <= next_cnt;
         wave <= next_wave;
      end
   end

endmodule

// ### src/alert_monitor_end.sv
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Contract
// - check all results after each conversion
// - four limits; outside any gives alert
// - static line rests high, low on fault
// - mode 00: no alert made or passed
// - mode 01: originate static high alert
// - mode 10: square wave, frequency by bits
// - mode 11: forward alert from above
// - local fault pulls chained alert low
// - host sets top originate, others forward
// - master gives alert as logic level
// - cell mask drops fifth, fourth cells
// - aux mask drops fifth, third aux
// - aux mask 00 follows converted aux set
// - host selects three aux before masking
// - self-test checked against cell limits
// - host self-tests the top monitor first
// - host may lower limits to test
// - conversion select picks converted inputs
module alert_monitor_end
   import alert_pkg::*;
#(
   parameter int SLOW = SLOW_HALF,
   parameter int MID  = MID_HALF,
   parameter int FAST = FAST_HALF
) (
   // clock and reset
   input  wire logic    clk,
   input  wire logic    rst_n,
   // register link and master alert
   alert_link_if.dev    link,
   // conversion results
   input  wire logic    conv_done,
   input  wire bank_t   cell_result,
   input  wire bank_t   aux_result,
   input  wire result_t self_result,
   // daisy chain
   input  wire logic    alert_from_above,
   output logic         alert_to_below,
   // state
   output logic         fault
);
   import alert_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] ctrl_hi;
   logic [7:0] ctrl_lo;
   limit_t     cell_over;
   limit_t     cell_under;
   limit_t     aux_over;
   limit_t     aux_under;
   logic [7:0] alert_cfg;
   logic       ack;
   logic [7:0] rdata;
   logic [7:0] next_ctrl_hi;
   logic [7:0] next_ctrl_lo;
   limit_t     next_cell_over;
   limit_t     next_cell_under;
   limit_t     next_aux_over;
   limit_t     next_aux_under;
   logic [7:0] next_alert_cfg;
   logic       next_ack;
   logic [7:0] next_rdata;
   logic       take;

   always_comb begin
      take            = link.req && !ack;
      next_ctrl_hi    = ctrl_hi;
      next_ctrl_lo    = ctrl_lo;
      next_cell_over  = cell_over;
      next_cell_under = cell_under;
      next_aux_over   = aux_over;
      next_aux_under  = aux_under;
      next_alert_cfg  = alert_cfg;
      next_ack        = take;
      next_rdata      = rdata;
      if (take && link.we) begin
         unique case (link.idx)
            IDX_CTRL_HI:    next_ctrl_hi    = link.wdata;
            IDX_CTRL_LO:    next_ctrl_lo    = link.wdata;
            IDX_CELL_OVER:  next_cell_over  = link.wdata;
            IDX_CELL_UNDER: next_cell_under = link.wdata;
            IDX_AUX_OVER:   next_aux_over   = link.wdata;
            IDX_AUX_UNDER:  next_aux_under  = link.wdata;
            IDX_ALERT_CFG:  next_alert_cfg  = link.wdata;
            default:        next_ctrl_hi    = ctrl_hi;
         endcase
      end
      if (take) begin
         unique case (link.idx)
            IDX_CTRL_HI:    next_rdata = ctrl_hi;
            IDX_CTRL_LO:    next_rdata = ctrl_lo;
            IDX_CELL_OVER:  next_rdata = cell_over;
            IDX_CELL_UNDER: next_rdata = cell_under;
            IDX_AUX_OVER:   next_rdata = aux_over;
            IDX_AUX_UNDER:  next_rdata = aux_under;
            IDX_ALERT_CFG:  next_rdata = alert_cfg;
            default:        next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_hi    <= CTRL_HI_RST;
         ctrl_lo    <= CTRL_LO_RST;
         cell_over  <= OVER_RST;
         cell_under <= UNDER_RST;
         aux_over   <= OVER_RST;
         aux_under  <= UNDER_RST;
         alert_cfg  <= ALERT_CFG_RST;
         ack        <= 1'b0;
         rdata      <= 8'h00;
      end else begin
         ctrl_hi    <= next_ctrl_hi;
         ctrl_lo    <= next_ctrl_lo;
         cell_over  <= next_cell_over;
         cell_under <= next_cell_under;
         aux_over   <= next_aux_over;
         aux_under  <= next_aux_under;
         alert_cfg  <= next_alert_cfg;
         ack        <= next_ack;
         rdata      <= next_rdata;
      end
   end

   assign link.ack   = ack;
   assign link.rdata = rdata;

   // ------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------
   conv_sel_t   conv_sel;
   alert_mode_t mode;
   freq_t       freq;
   mask_t       cell_mask;
   mask_t       aux_mask;

   assign conv_sel  = conv_sel_t'(ctrl_hi[SEL_LSB +: 2]);
   assign mode      = alert_mode_t'(alert_cfg[MODE_LSB +: 2]);
   assign freq      = freq_t'(alert_cfg[FREQ_LSB +: 2]);
   assign cell_mask = mask_t'(alert_cfg[CMASK_LSB +: 2]);
   assign aux_mask  = mask_t'(alert_cfg[AMASK_LSB +: 2]);

   // ------------------------------------------------------------
   // limit check
   // ------------------------------------------------------------
   // limits meet the top result bits
   function automatic logic outside(input result_t res, input limit_t over,
                                    input limit_t under);
      logic [LIMIT_W-1:0] top;
      top     = res[LIMIT_LSB +: LIMIT_W];
      outside = (top > over) || (top < under);
   endfunction

   logic [CHANNELS-1:0] cell_chk;
   logic [CHANNELS-1:0] aux_chk;
   logic                any_out;

   always_comb begin
      cell_chk = '1;
      aux_chk  = '0;
      // reserved mask codes drop no channel
      if (cell_mask == MASK_ONE || cell_mask == MASK_TWO) begin
         cell_chk[CELL_INPUT_FIVE] = 1'b0;
      end
      if (cell_mask == MASK_TWO) begin
         cell_chk[CELL_INPUT_FOUR] = 1'b0;
      end
      unique case (conv_sel)
         SEL_ALL:     aux_chk = '1;
         SEL_ODD_AUX: aux_chk = ODD_AUX;
         SEL_CELLS:   aux_chk = '0;
         SEL_SELF:    cell_chk = '0;
      endcase
      // aux masks assume three-aux select
      if (aux_mask == MASK_ONE || aux_mask == MASK_TWO) begin
         aux_chk[AUX_INPUT_FIVE] = 1'b0;
      end
      if (aux_mask == MASK_TWO) begin
         aux_chk[AUX_INPUT_THREE] = 1'b0;
      end
      any_out = 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
         if (cell_chk[i] && outside(cell_result[i], cell_over, cell_under)) begin
            any_out = 1'b1;
         end
         if (aux_chk[i] && outside(aux_result[i], aux_over, aux_under)) begin
            any_out = 1'b1;
         end
      end
      if (conv_sel == SEL_SELF && outside(self_result, cell_over, cell_under)) begin
         any_out = 1'b1;
      end
   end

   logic next_fault;

   always_comb begin
      next_fault = fault;
      if (conv_done) begin
         next_fault = any_out;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fault <= 1'b0;
      end else begin
         fault <= next_fault;
      end
   end

   // ------------------------------------------------------------
   // chain input synchroniser and output drive
   // ------------------------------------------------------------
   logic above_meta;
   logic above_sync;
   logic wave;
   logic next_alert;

   square_wave_gen #(
      .SLOW (SLOW),
      .MID  (MID),
      .FAST (FAST)
   ) u_wave (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (mode == MODE_SQUARE && freq != FREQ_RSV && !fault),
      .freq  (freq),
      .wave  (wave)
   );

   always_comb begin
      unique case (mode)
         MODE_OFF:    next_alert = 1'b0;
         MODE_STATIC: next_alert = !fault;
         // reserved frequency stays low
         MODE_SQUARE: next_alert = !fault && freq != FREQ_RSV && wave;
         MODE_PASS:   next_alert = above_sync && !fault;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         above_meta     <= 1'b0;
         above_sync     <= 1'b0;
         alert_to_below <= 1'b0;
      end else begin
         above_meta     <= alert_from_above;
         above_sync     <= above_meta;
         alert_to_below <= next_alert;
      end
   end

   // master passes the level on
   assign link.alert_level = alert_to_below;

endmodule

// ### src/alert_host_end.sv
`timescale 1ns/1ps
module alert_host_end
   import alert_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // device link
   alert_link_if.host       link
);
   import alert_pkg::*;

   typedef enum logic {H_IDLE, H_WAIT} host_state_t;

   host_state_t state;
   host_state_t next_state;
   logic        req;
   logic        we;
   logic [4:0]  idx;
   logic [7:0]  wdata;
   logic [7:0]  rd_hold;
   logic [1:0]  sel_shadow;
   logic        seen;
   logic        refused;
   logic        lvl_meta;
   logic        lvl_sync;
   logic        next_req;
   logic        next_we;
   logic [4:0]  next_idx;
   logic [7:0]  next_wdata;
   logic [7:0]  next_rd_hold;
   logic [1:0]  next_sel_shadow;
   logic        next_seen;
   logic        next_refused;
   logic [31:0] next_prdata;
   logic        wr_cmd;
   logic        bad_mask;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   assign pready  = 1'b1;
   assign pslverr = psel && penable &&
                    !(paddr == HOST_CMD || paddr == HOST_STATUS || paddr == HOST_RDATA);

   always_comb begin
      wr_cmd   = psel && penable && pwrite && paddr == HOST_CMD;
      // aux masks need the three-aux selection first
      bad_mask = pwdata[CMD_WE_BIT] && pwdata[CMD_IDX_LSB +: 5] == IDX_ALERT_CFG &&
                 (pwdata[AMASK_LSB +: 2] == MASK_ONE || pwdata[AMASK_LSB +: 2] == MASK_TWO) &&
                 sel_shadow != SEL_ODD_AUX;
      next_state      = state;
      next_req        = req;
      next_we         = we;
      next_idx        = idx;
      next_wdata      = wdata;
      next_rd_hold    = rd_hold;
      next_sel_shadow = sel_shadow;
      next_refused    = refused;
      next_seen       = seen;
      unique case (state)
         H_IDLE: begin
            if (wr_cmd && !bad_mask) begin
               next_req   = 1'b1;
               next_we    = pwdata[CMD_WE_BIT];
               next_idx   = pwdata[CMD_IDX_LSB +: 5];
               next_wdata = pwdata[CMD_DATA_LSB +: 8];
               next_state = H_WAIT;
               if (pwdata[CMD_WE_BIT] && pwdata[CMD_IDX_LSB +: 5] == IDX_CTRL_HI) begin
                  next_sel_shadow = pwdata[SEL_LSB +: 2];
               end
            end
         end
         H_WAIT: begin
            if (link.ack) begin
               next_req   = 1'b0;
               next_state = H_IDLE;
               if (!we) begin
                  next_rd_hold = link.rdata;
               end
            end
         end
      endcase
      // set beats write-one clear
      if (psel && penable && pwrite && paddr == HOST_STATUS) begin
         if (pwdata[ST_SEEN]) begin
            next_seen = 1'b0;
         end
         if (pwdata[ST_REFUSED]) begin
            next_refused = 1'b0;
         end
      end
      if (wr_cmd && state == H_IDLE && bad_mask) begin
         next_refused = 1'b1;
      end
      // latches any chain alert
      if (!lvl_sync) begin
         next_seen = 1'b1;
      end
      next_prdata = prdata;
      if (psel && !penable) begin
         unique case (paddr)
            HOST_STATUS: next_prdata = {28'h0000000, refused, seen, lvl_sync,
                                        state == H_WAIT};
            HOST_RDATA:  next_prdata = {24'h000000, rd_hold};
            HOST_CMD:    next_prdata = {7'h00, we, 3'h0, idx, 8'h00, wdata};
            default:     next_prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state      <= H_IDLE;
         req        <= 1'b0;
         we         <= 1'b0;
         idx        <= 5'h00;
         wdata      <= 8'h00;
         rd_hold    <= 8'h00;
         sel_shadow <= SEL_ALL;
         seen       <= 1'b0;
         refused    <= 1'b0;
         lvl_meta   <= 1'b1;
         lvl_sync   <= 1'b1;
         prdata     <= 32'h00000000;
      end else begin
         state      <= next_state;
         req        <= next_req;
         we         <= next_we;
         idx        <= next_idx;
         wdata      <= next_wdata;
         rd_hold    <= next_rd_hold;
         sel_shadow <= next_sel_shadow;
         seen       <= next_seen;
         refused    <= next_refused;
         lvl_meta   <= link.alert_level;
         lvl_sync   <= lvl_meta;
         prdata     <= next_prdata;
      end
   end

   // software sets top to originate
   assign link.req   = req;
   assign link.we    = we;
   assign link.idx   = idx;
   assign link.wdata = wdata;

endmodule

// ### dv/alert_link_chk.sv
`timescale 1ns/1ps
module alert_link_chk
   import alert_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // link
   input wire logic       req,
   input wire logic       we,
   input wire logic [4:0] idx,
   input wire logic [7:0] wdata,
   input wire logic       ack,
   input wire logic [7:0] rdata,
   input wire logic       alert_level
);
   // ------------------------------
   // alert config shadow
   // ------------------------------
   logic [7:0] cfg;
   logic [7:0] next_cfg;
   logic       take;
   logic       unmapped;
   assign take     = req && !ack;
   assign unmapped = (idx < IDX_CTRL_HI) || (idx > IDX_ALERT_CFG);
   always_comb begin
      next_cfg = cfg;
      if (take && we && idx == IDX_ALERT_CFG) begin
         next_cfg = wdata;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg <= ALERT_CFG_RST;
      end else begin
         cfg <= next_cfg;
      end
   end
   // ------------------------------
   // properties
   // ------------------------------
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   chk_ack_after_take: assert property (take |=> ack)
      else $error("no ack after take");
   chk_ack_one_cycle: assert property (ack |=> !ack)
      else $error("ack too long");
   chk_ack_has_cause: assert property (ack |-> $past(take))
      else $error("ack without take");
   chk_req_held_steady: assert property (take |=> req && $stable(idx) && $stable(we)
      && $stable(wdata))
      else $error("request moved before ack");
   chk_req_drop_ack: assert property (ack |=> !req)
      else $error("req held after ack");
   chk_rdata_hold: assert property (!ack |-> $stable(rdata))
      else $error("rdata moved");
   chk_cfg_readback: assert property (take && !we && idx == IDX_ALERT_CFG
      |=> rdata == cfg)
      else $error("cfg readback wrong");
   chk_unknown_zero: assert property (take && !we && unmapped |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   // mode off holds the chain low
   chk_off_mode_low: assert property (($past(cfg[7:6]) == MODE_OFF && cfg[7:6] == MODE_OFF)
      |-> !alert_level)
      else $error("alert high in mode off");
   cover property (take && we && idx == IDX_ALERT_CFG);
   cover property (take && !we && unmapped);
   cover property ($fell(alert_level));
endmodule

// ### dv/threshold_alert_output_tb_top.sv
`timescale 1ns/1ps
module threshold_alert_output_tb_top;
   import alert_pkg::*;
   // ------------------------------
   // signals
   // ------------------------------
   localparam int SLOW_T = 8;
   localparam int MID_T  = 4;
   localparam int FAST_T = 2;
   logic        clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        conv_done;
   bank_t       cell_result;
   bank_t       aux_result;
   result_t     self_result;
   logic        alert_from_above;
   logic        alert_to_below;
   logic        fault;
   logic [31:0] rd;
   logic        slv;
   int          error_cnt;
   int          cmp_count;
   int          cyc;
   int          hp [3] = '{SLOW_T, MID_T, FAST_T};
   logic [12:0] rst_tab [4] = '{{IDX_CTRL_LO, CTRL_LO_RST}, {IDX_CELL_OVER, OVER_RST},
                                {IDX_CELL_UNDER, UNDER_RST}, {IDX_ALERT_CFG, ALERT_CFG_RST}};
   // cfg, ctrl_hi, kind (0 cell 1 aux 2 self), channel, result, fault
   logic [39:0] rows [17] = '{40'h40_00_0_0_500_0, 40'h40_00_0_2_900_1, 40'h40_00_0_5_100_1,
      40'h40_00_1_1_900_1, 40'h40_00_1_3_100_1, 40'h44_00_0_4_900_0, 40'h44_00_0_3_900_1,
      40'h48_00_0_3_100_0, 40'h4c_00_0_4_900_1, 40'h40_40_1_1_900_0, 40'h40_40_1_2_900_1,
      40'h41_40_1_4_900_0, 40'h42_40_1_2_100_0, 40'h42_40_1_0_900_1, 40'h40_80_1_0_900_0,
      40'h40_c0_2_0_100_1, 40'h40_c0_0_0_900_0};
   // ------------------------------
   // ends and checker
   // ------------------------------
   alert_link_if u_alert_link_if ();
   alert_host_end u_alert_host_end (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(u_alert_link_if));
   // short half periods keep runs quick
   alert_monitor_end #(.SLOW(SLOW_T), .MID(MID_T), .FAST(FAST_T)) u_alert_monitor_end (
      .clk(clk), .rst_n(rst_n), .link(u_alert_link_if), .conv_done(conv_done),
      .cell_result(cell_result), .aux_result(aux_result), .self_result(self_result),
      .alert_from_above(alert_from_above), .alert_to_below(alert_to_below), .fault(fault));
   alert_link_chk u_alert_link_chk (.clk(clk), .rst_n(rst_n), .req(u_alert_link_if.req),
      .we(u_alert_link_if.we), .idx(u_alert_link_if.idx), .wdata(u_alert_link_if.wdata),
      .ack(u_alert_link_if.ack), .rdata(u_alert_link_if.rdata),
      .alert_level(u_alert_link_if.alert_level));
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // polls busy: a command while busy is dropped
   task automatic dev(input logic w, input logic [4:0] i, input logic [7:0] d);
      apb(1'b1, HOST_CMD, {7'h00, w, 3'h0, i, 8'h00, d});
      rd = 32'h1;
      while (rd[ST_BUSY] !== 1'b0) apb(1'b0, HOST_STATUS, 32'h0);
      if (!w) apb(1'b0, HOST_RDATA, 32'h0);
   endtask
   task automatic convert(input logic [1:0] k, input logic [3:0] ch, input result_t v);
      bank_t c;
      bank_t a;
      c = {CHANNELS{12'h500}};
      a = {CHANNELS{12'h500}};
      if (k == 2'd0) c[ch] = v;
      if (k == 2'd1) a[ch] = v;
      @(posedge clk);
      cell_result <= c;
      aux_result <= a;
      self_result <= (k == 2'd2) ? v : 12'h500;
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      repeat (4) @(negedge clk);
   endtask
   task automatic half_period(output int n);
      logic v;
      n = 0;
      @(negedge clk);
      v = alert_to_below;
      while (alert_to_below === v) @(negedge clk);
      v = alert_to_below;
      while (alert_to_below === v) begin
         @(negedge clk);
         n++;
      end
   endtask
   // ------------------------------
   // clock, timeout, sequence
   // ------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      cyc = 0;
      forever begin
         @(posedge clk);
         cyc++;
         if (cyc == 30000) begin
            error_cnt++;
            stop_test();
         end
      end
   end
   initial begin
      int n;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      conv_done = 1'b0;
      cell_result = '0;
      aux_result = '0;
      self_result = '0;
      alert_from_above = 1'b1;
      error_cnt = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      check(fault, 1'b0);
      check(u_alert_link_if.alert_level, 1'b0);
      for (int i = 0; i < 4; i++) begin
         dev(1'b0, rst_tab[i][12:8], 8'h00);
         check(rd[7:0], rst_tab[i][7:0]);
      end
      dev(1'b0, 5'h1f, 8'h00);
      check(rd[7:0], 8'h00);
      dev(1'b1, IDX_CELL_OVER, 8'h80);
      dev(1'b1, IDX_CELL_UNDER, 8'h20);
      dev(1'b1, IDX_AUX_OVER, 8'h80);
      dev(1'b1, IDX_AUX_UNDER, 8'h20);
      // mode off: fault, no alert
      convert(2'd0, 4'd0, 12'h900);
      check(fault, 1'b1);
      check(u_alert_link_if.alert_level, 1'b0);
      for (int r = 0; r < 17; r++) begin
         dev(1'b1, IDX_CTRL_HI, rows[r][31:24]);
         dev(1'b1, IDX_ALERT_CFG, rows[r][39:32]);
         convert(rows[r][21:20], rows[r][19:16], rows[r][15:4]);
         check(fault, rows[r][0]);
         check(u_alert_link_if.alert_level, !rows[r][0]);
      end
      dev(1'b1, IDX_CTRL_HI, 8'h00);
      dev(1'b1, IDX_ALERT_CFG, 8'hc0);
      convert(2'd0, 4'd0, 12'h500);
      check(alert_to_below, 1'b1);
      @(posedge clk);
      alert_from_above <= 1'b0;
      repeat (5) @(negedge clk);
      check(alert_to_below, 1'b0);
      @(posedge clk);
      alert_from_above <= 1'b1;
      convert(2'd1, 4'd5, 12'h900);
      check(alert_to_below, 1'b0);
      convert(2'd0, 4'd0, 12'h500);
      check(alert_to_below, 1'b1);
      for (int f = 0; f < 3; f++) begin
         dev(1'b1, IDX_ALERT_CFG, {2'b10, f[1:0], 4'h0});
         half_period(n);
         check(n, hp[f]);
      end
      dev(1'b1, IDX_ALERT_CFG, 8'hb0);
      repeat (4) @(negedge clk);
      check(alert_to_below, 1'b0);
      dev(1'b1, IDX_ALERT_CFG, 8'ha0);
      convert(2'd0, 4'd1, 12'h100);
      repeat (3 * SLOW_T) @(negedge clk);
      check(alert_to_below, 1'b0);
      convert(2'd0, 4'd0, 12'h500);
      half_period(n);
      check(n, FAST_T);
      // aux mask needs three-aux select
      dev(1'b1, IDX_ALERT_CFG, 8'h40);
      dev(1'b1, IDX_ALERT_CFG, 8'h41);
      apb(1'b0, HOST_STATUS, 32'h0);
      check(rd[ST_REFUSED], 1'b1);
      dev(1'b0, IDX_ALERT_CFG, 8'h00);
      check(rd[7:0], 8'h40);
      convert(2'd0, 4'd2, 12'h900);
      apb(1'b0, HOST_STATUS, 32'h0);
      check(rd[ST_ALERT], 1'b0);
      apb(1'b0, 12'h00c, 32'h0);
      check(slv, 1'b1);
      stop_test();
   end
endmodule
